// *** rtl/dad_params.svh ***
// Constants of the drive alarm detector: offsets, alarm codes, resets and timing counts
`ifndef DAD_PARAMS_SVH
`define DAD_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DAD_OFF_CTRL 12'h000
`define DAD_OFF_STAT 12'h004
`define DAD_OFF_OVLD 12'h008
`define DAD_OFF_DEVI 12'h00c
`define DAD_OFF_CERR 12'h010
`define DAD_OFF_CTMO 12'h014

// ----------------------------------------
// Alarm codes and blink counts
// ----------------------------------------
`define DAD_CODE_NONE 8'h00
`define DAD_CODE_OPDATA 8'h70
`define DAD_CODE_GEAR 8'h71
`define DAD_CODE_WRAP 8'h72
`define DAD_CODE_NETBUS 8'h81
`define DAD_CODE_BAUD 8'h83
`define DAD_CODE_COMERR 8'h84
`define DAD_CODE_COMTMO 8'h85
`define DAD_CODE_NETCONV 8'h8e
`define DAD_CODE_CPU 8'hf0
`define DAD_BLINK_STD 4'h7
`define DAD_BLINK_LIT 4'hf

// ----------------------------------------
// Thresholds, ranges and resets
// ----------------------------------------
`define DAD_OVLD_MIN 16'h0001
`define DAD_OVLD_MAX 16'h012c
`define DAD_OVLD_RST 16'h0032
`define DAD_DEVI_MIN 16'h0001
`define DAD_DEVI_MAX 16'h7530
`define DAD_DEVI_RST 16'h012c
`define DAD_CERR_RST 8'h03
`define DAD_CTMO_RST 16'h0000
`define DAD_NC_FAIL_LIMIT 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define DAD_CLK_MHZ 125
`define DAD_NC_TMO_MS 200
`define DAD_NC_TMO_CYC (`DAD_NC_TMO_MS * 1000 * `DAD_CLK_MHZ)
`define DAD_MS_CYC (1000 * `DAD_CLK_MHZ)

`endif

// *** rtl/dad_pkg.sv ***
// Types of the drive alarm detector
package dad_pkg;
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] blinks;
    logic resettable;
    logic excite;
  } dad_alarm_s;

  typedef struct packed {
    logic zero_speed_op;
    logic wrap_op_no_wrap;
    logic mech_limit_exceed;
    logic gear_out_of_range;
    logic wrap_inconsistent;
    logic net_disconnect;
    logic baud_invalid;
    logic comm_error;
    logic comm_ok;
    logic nc_comm_fail;
    logic nc_comm_ok;
    logic nc_alarm;
    logic cpu_fault;
  } dad_evt_s;

  typedef enum logic [1:0] {
    DAD_IDLE = 2'b00,
    DAD_ALARM = 2'b01,
    DAD_LOCKED = 2'b10
  } dad_state_e;
endpackage

// *** rtl/dad_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dad_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and result
  input wire logic pin_in,
  output logic pin_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  // Only s2 reads s1; the filter looks at s2 and s3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  assign pin_out = out_q;
endmodule

// *** rtl/dad_top.sv ***
// Alarm detection, latching and excitation control of the drive, with APB registers
// Functional notes
// - Zero speed or mechanism limit exceeded raises 70h, seven blinks, resettable, excited.
// - Wrap operation with wrap disabled also raises 70h.
// - Gear resolution out of range raises 71h, seven blinks, not resettable, unexcited.
// - Wrap/gear mismatch at power-up raises 72h, not resettable, unexcited.
// - Network master disconnect raises 81h, resettable, excited.
// - Invalid baud switch raises 83h, not resettable, unexcited.
// - Consecutive serial errors reaching threshold raise 84h, resettable, excited.
// - Three consecutive converter link failures also raise 84h.
// - Converter link unestablished for 200 ms also raises 85h.
// - Converter alarm raises 8Eh, resettable, unexcited.
// - Non-excitation alarms cut motor current.
// - Excitation alarms keep motor current flowing.
// - De-energizing alarm engages the brake.
// - Overload threshold 1 to 300 in 0.1 s, default 50.
// - Deviation threshold 1 to 30000 in 0.01 rev, default 300.
`timescale 1ns/1ps
`include "dad_params.svh"
module dad_top #(
  parameter int NC_TMO_CYC = `DAD_NC_TMO_CYC,
  parameter int MS_CYC = `DAD_MS_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Alarm clear pin
  input wire logic alarm_clear_input,
  // Detection events from drive logic
  input wire dad_pkg::dad_evt_s evt,
  input wire logic wrap_inconsistent_boot,
  // Alarm outputs
  output logic alarm_active,
  output logic [7:0] alarm_code,
  output logic [3:0] led_blinks,
  output logic motor_excite,
  output logic brake_engage,
  // Thresholds to the overload and deviation detectors
  output logic [15:0] ovld_thresh,
  output logic [15:0] devi_thresh
);
  // ----------------------------------------
  // Pin input
  // ----------------------------------------
  logic clr_pin;
  logic clr_pin_q;
  dad_sync u_clr_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(alarm_clear_input),
    .pin_out(clr_pin)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ovld_q;
  logic [15:0] devi_q;
  logic [7:0] cerr_q;
  logic [15:0] ctmo_q;
  logic [7:0] cerr_cnt_q;
  logic [1:0] nc_fail_q;
  logic [31:0] nc_tmo_q;
  logic [31:0] ms_q;
  logic [15:0] ctmo_cnt_q;
  logic boot_q;
  dad_pkg::dad_state_e state_q;
  dad_pkg::dad_alarm_s alarm_q;
  logic [31:0] prdata_q;

  wire wr_en = psel && penable && pwrite;
  wire sel_ctrl = paddr == `DAD_OFF_CTRL;
  wire sel_stat = paddr == `DAD_OFF_STAT;
  wire sel_ovld = paddr == `DAD_OFF_OVLD;
  wire sel_devi = paddr == `DAD_OFF_DEVI;
  wire sel_cerr = paddr == `DAD_OFF_CERR;
  wire sel_ctmo = paddr == `DAD_OFF_CTMO;
  wire mapped = sel_ctrl || sel_stat || sel_ovld || sel_devi || sel_cerr || sel_ctmo;
  wire sw_clear = wr_en && sel_ctrl && pwdata[0];
  wire ovld_ok = pwdata[15:0] >= `DAD_OVLD_MIN && pwdata[15:0] <= `DAD_OVLD_MAX;
  wire devi_ok = pwdata[15:0] >= `DAD_DEVI_MIN && pwdata[15:0] <= `DAD_DEVI_MAX;
  // Out-of-range threshold writes are refused and flagged
  wire bad_wr = wr_en && ((sel_ovld && !ovld_ok) || (sel_devi && !devi_ok) || sel_stat);

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || bad_wr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovld_q <= `DAD_OVLD_RST;
      devi_q <= `DAD_DEVI_RST;
      cerr_q <= `DAD_CERR_RST;
      ctmo_q <= `DAD_CTMO_RST;
    end else begin
      if (wr_en && sel_ovld && ovld_ok) begin
        ovld_q <= pwdata[15:0];
      end
      if (wr_en && sel_devi && devi_ok) begin
        devi_q <= pwdata[15:0];
      end
      if (wr_en && sel_cerr) begin
        cerr_q <= pwdata[7:0];
      end
      if (wr_en && sel_ctmo) begin
        ctmo_q <= pwdata[15:0];
      end
    end
  end

  assign ovld_thresh = ovld_q;
  assign devi_thresh = devi_q;

  wire [31:0] stat_word = {16'h0000, alarm_q.code, alarm_q.blinks, 1'b0, alarm_q.resettable,
                           alarm_q.excite, alarm_active};
  wire [31:0] rd_word = sel_stat ? stat_word :
                        sel_ovld ? {16'h0000, ovld_q} :
                        sel_devi ? {16'h0000, devi_q} :
                        sel_cerr ? {24'h000000, cerr_q} :
                        sel_ctmo ? {16'h0000, ctmo_q} : 32'h00000000;
  // Read word is captured in the setup cycle, so prdata comes from a flip-flop with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= (psel && !penable && !pwrite) ? rd_word : 32'h00000000;
    end
  end
  assign prdata = prdata_q;

  // ----------------------------------------
  // Communication counters
  // ----------------------------------------
  wire cerr_hit = evt.comm_error && (cerr_cnt_q + 8'h01 >= cerr_q) && (cerr_q != 8'h00);
  wire nc_fail_hit = evt.nc_comm_fail && (nc_fail_q + 2'h1 == `DAD_NC_FAIL_LIMIT);
  wire nc_tmo_hit = !evt.nc_comm_ok && (nc_tmo_q == 32'(NC_TMO_CYC - 1));
  wire ms_tick = ms_q == 32'(MS_CYC - 1);
  // Zero timeout setting disables the master timeout
  wire ctmo_hit = ms_tick && !evt.comm_ok && (ctmo_q != 16'h0000) && (ctmo_cnt_q + 16'h0001 == ctmo_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cerr_cnt_q <= 8'h00;
      nc_fail_q <= 2'h0;
      nc_tmo_q <= 32'h00000000;
      ms_q <= 32'h00000000;
      ctmo_cnt_q <= 16'h0000;
    end else begin
      if (evt.comm_ok) begin
        cerr_cnt_q <= 8'h00;
      end else if (evt.comm_error && !cerr_hit) begin
        cerr_cnt_q <= cerr_cnt_q + 8'h01;
      end else if (cerr_hit) begin
        cerr_cnt_q <= 8'h00;
      end
      if (evt.nc_comm_ok || nc_fail_hit) begin
        nc_fail_q <= 2'h0;
      end else if (evt.nc_comm_fail) begin
        nc_fail_q <= nc_fail_q + 2'h1;
      end
      if (evt.nc_comm_ok || nc_tmo_hit) begin
        nc_tmo_q <= 32'h00000000;
      end else begin
        nc_tmo_q <= nc_tmo_q + 32'h00000001;
      end
      ms_q <= ms_tick ? 32'h00000000 : ms_q + 32'h00000001;
      if (evt.comm_ok || ctmo_hit) begin
        ctmo_cnt_q <= 16'h0000;
      end else if (ms_tick && ctmo_q != 16'h0000) begin
        ctmo_cnt_q <= ctmo_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Alarm selection, highest severity first
  // ----------------------------------------
  wire boot_chk = !boot_q && wrap_inconsistent_boot;
  wire opdata = evt.zero_speed_op || evt.mech_limit_exceed || evt.wrap_op_no_wrap;
  dad_pkg::dad_alarm_s new_alarm;
  logic new_hit;

  always_comb begin
    new_hit = 1'b1;
    new_alarm = '{`DAD_CODE_NONE, 4'h0, 1'b1, 1'b1};
    if (evt.cpu_fault) begin
      new_alarm = '{`DAD_CODE_CPU, `DAD_BLINK_LIT, 1'b0, 1'b0};
    end else if (boot_chk) begin
      new_alarm = '{`DAD_CODE_WRAP, `DAD_BLINK_STD, 1'b0, 1'b0};
    end else if (evt.gear_out_of_range) begin
      new_alarm = '{`DAD_CODE_GEAR, `DAD_BLINK_STD, 1'b0, 1'b0};
    end else if (evt.baud_invalid) begin
      new_alarm = '{`DAD_CODE_BAUD, `DAD_BLINK_STD, 1'b0, 1'b0};
    end else if (evt.nc_alarm) begin
      new_alarm = '{`DAD_CODE_NETCONV, `DAD_BLINK_STD, 1'b1, 1'b0};
    end else if (evt.net_disconnect) begin
      new_alarm = '{`DAD_CODE_NETBUS, `DAD_BLINK_STD, 1'b1, 1'b1};
    end else if (cerr_hit || nc_fail_hit) begin
      new_alarm = '{`DAD_CODE_COMERR, `DAD_BLINK_STD, 1'b1, 1'b1};
    end else if (ctmo_hit || nc_tmo_hit) begin
      new_alarm = '{`DAD_CODE_COMTMO, `DAD_BLINK_STD, 1'b1, 1'b1};
    end else if (opdata) begin
      new_alarm = '{`DAD_CODE_OPDATA, `DAD_BLINK_STD, 1'b1, 1'b1};
    end else begin
      new_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // Latch and clear
  // ----------------------------------------
  wire clr_req = (clr_pin && !clr_pin_q) || sw_clear;
  // A new detection in the clear cycle wins over the clear
  wire take_new = new_hit && (state_q == dad_pkg::DAD_IDLE);
  // Only a non-resettable alarm displaces a latched resettable one
  wire replace = new_hit && (state_q == dad_pkg::DAD_IDLE ||
                 (state_q == dad_pkg::DAD_ALARM && !new_alarm.resettable));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dad_pkg::DAD_IDLE;
      alarm_q <= '{`DAD_CODE_NONE, 4'h0, 1'b1, 1'b1};
      boot_q <= 1'b0;
      clr_pin_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
      clr_pin_q <= clr_pin;
      case (state_q)
        dad_pkg::DAD_IDLE: begin
          if (take_new) begin
            alarm_q <= new_alarm;
            state_q <= new_alarm.resettable ? dad_pkg::DAD_ALARM : dad_pkg::DAD_LOCKED;
          end
        end
        dad_pkg::DAD_ALARM: begin
          if (replace) begin
            alarm_q <= new_alarm;
            state_q <= dad_pkg::DAD_LOCKED;
          end else if (clr_req && !new_hit) begin
            alarm_q <= '{`DAD_CODE_NONE, 4'h0, 1'b1, 1'b1};
            state_q <= dad_pkg::DAD_IDLE;
          end
        end
        dad_pkg::DAD_LOCKED: begin
          // Only power-up leaves this state; clear requests are ignored
          if (evt.cpu_fault && alarm_q.code != `DAD_CODE_CPU) begin
            alarm_q <= new_alarm;
          end
        end
        default: begin
          state_q <= dad_pkg::DAD_IDLE;
        end
      endcase
    end
  end

  assign alarm_active = state_q != dad_pkg::DAD_IDLE;
  assign alarm_code = alarm_q.code;
  assign led_blinks = alarm_q.blinks;
  assign motor_excite = !alarm_active || alarm_q.excite;
  assign brake_engage = !motor_excite;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_locked_stays: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == dad_pkg::DAD_LOCKED |=> state_q == dad_pkg::DAD_LOCKED)
    else $error("Locked alarm left its state");
  a_gear_unexcited: assert property (@(posedge pclk) disable iff (!presetn)
    evt.gear_out_of_range && state_q == dad_pkg::DAD_IDLE && !evt.cpu_fault && !boot_chk
    |=> alarm_code == 8'h71 && !motor_excite)
    else $error("Gear alarm not raised as 71h without excitation");
  a_opdata_code: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == dad_pkg::DAD_IDLE && new_hit && new_alarm.code == 8'h70
    |=> alarm_code == 8'h70 && led_blinks == 4'h7 && motor_excite)
    else $error("Operation data alarm wrong");
  a_brake_cut: assert property (@(posedge pclk) disable iff (!presetn)
    brake_engage == (alarm_active && !alarm_q.excite))
    else $error("Brake not tied to current cut");
  a_nc_excite: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_code == 8'h8e |-> !motor_excite)
    else $error("Converter alarm kept excitation");
  a_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == dad_pkg::DAD_ALARM && sw_clear && !new_hit |=> !alarm_active)
    else $error("Permitted clear ignored");
  a_cpu_lit: assert property (@(posedge pclk) disable iff (!presetn)
    evt.cpu_fault |=> alarm_code == 8'hf0 && led_blinks == 4'hf)
    else $error("Processor fault not shown");
  a_nc_fail_three: assert property (@(posedge pclk) disable iff (!presetn)
    nc_fail_q == 2'h2 && evt.nc_comm_fail && !evt.nc_comm_ok |=> nc_fail_q == 2'h0)
    else $error("Converter failure count wrong");
  a_ovld_range: assert property (@(posedge pclk) disable iff (!presetn)
    ovld_q >= 16'h0001 && ovld_q <= 16'h012c)
    else $error("Overload threshold out of range");
  a_devi_range: assert property (@(posedge pclk) disable iff (!presetn)
    devi_q >= 16'h0001 && devi_q <= 16'h7530)
    else $error("Deviation threshold out of range");
  a_boot_lock: assert property (@(posedge pclk) disable iff (!presetn)
    boot_chk && !evt.cpu_fault |=> alarm_code == 8'h72 && state_q == dad_pkg::DAD_LOCKED && !motor_excite)
    else $error("Power-up wrap mismatch not locked as 72h");
  a_baud_lock: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_code == 8'h83 |-> state_q == dad_pkg::DAD_LOCKED && !motor_excite && brake_engage)
    else $error("Baud switch alarm not locked without excitation");
  a_net_excited: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_code == 8'h81 |-> alarm_active && motor_excite && !brake_engage)
    else $error("Network bus alarm lost excitation");
  a_comerr_kind: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_code == 8'h84 |-> state_q == dad_pkg::DAD_ALARM && motor_excite)
    else $error("Communication error alarm not resettable and excited");
  a_cerr_reach: assert property (@(posedge pclk) disable iff (!presetn)
    cerr_q == 8'h03 && cerr_cnt_q == 8'h02 && evt.comm_error && !evt.comm_ok
    |=> alarm_active && cerr_cnt_q == 8'h00)
    else $error("Serial error threshold did not raise an alarm");
  a_tmo_kind: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_code == 8'h85 |-> state_q == dad_pkg::DAD_ALARM && motor_excite)
    else $error("Communication timeout alarm not resettable and excited");
  a_nc_tmo_raise: assert property (@(posedge pclk) disable iff (!presetn)
    nc_tmo_q == 32'(NC_TMO_CYC - 1) && !evt.nc_comm_ok |=> alarm_active && nc_tmo_q == 32'h00000000)
    else $error("Converter link timeout not raised");
  a_lock_kind: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == dad_pkg::DAD_LOCKED |-> !alarm_q.resettable)
    else $error("Resettable alarm held as locked");
  a_excite_kept: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_active && alarm_q.excite |-> motor_excite && !brake_engage)
    else $error("Excitation alarm cut motor current");
  c_timeout: cover property (@(posedge pclk) disable iff (!presetn)
    alarm_code == 8'h85);
  c_boot: cover property (@(posedge pclk) disable iff (!presetn)
    alarm_code == 8'h72);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) state_q == dad_pkg::DAD_LOCKED);
  c_clear: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == dad_pkg::DAD_ALARM ##1 state_q == dad_pkg::DAD_IDLE);
  c_comerr: cover property (@(posedge pclk) disable iff (!presetn) alarm_code == 8'h84);
endmodule

// *** testbench/dad_far_model.sv ***
// Behavioural model of the master controller and network converter side
`timescale 1ns/1ps
module dad_far_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic cmd_valid,
  input wire logic [2:0] cmd,
  // Events seen by the detector
  output logic link_up,
  output logic fail_p,
  output logic alarm_p,
  output logic drop_p
);
  // ----------------------------------------
  // Link state and one-cycle reports
  // ----------------------------------------
  // Link comes up with reset so the converter timer stays quiet unless a test drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_up <= 1'b1;
      fail_p <= 1'b0;
      alarm_p <= 1'b0;
      drop_p <= 1'b0;
    end else begin
      fail_p <= cmd_valid && cmd == 3'h2;
      alarm_p <= cmd_valid && cmd == 3'h3;
      drop_p <= cmd_valid && cmd == 3'h4;
      if (cmd_valid && cmd[2:1] == 2'b00) begin
        link_up <= cmd[0];
      end else if (cmd_valid && cmd == 3'h2) begin
        // A failed exchange leaves the converter link down until it is raised again
        link_up <= 1'b0;
      end
    end
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench of the drive alarm detector
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr_pin, boot_bad, cmd_valid;
  logic alarm_active, motor_excite, brake_engage, link_up, fail_p, alarm_p, drop_p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] alarm_code;
  logic [3:0] led_blinks;
  logic [15:0] ovld_thresh, devi_thresh;
  logic [12:0] ev_bits;
  logic [2:0] cmd;
  dad_pkg::dad_evt_s evt;
  int errors, n_compared, cycles;
  typedef struct {int b; logic [7:0] code; logic [3:0] bl; logic exc; logic rst;} dad_row_s;
  dad_row_s rows[6];
  assign evt = dad_pkg::dad_evt_s'(ev_bits | {5'h00, drop_p, 3'h0, fail_p, link_up, alarm_p, 1'b0});

  dad_top #(.NC_TMO_CYC(50), .MS_CYC(10)) i_dad_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_clear_input(clr_pin), .evt(evt), .wrap_inconsistent_boot(boot_bad),
    .alarm_active(alarm_active), .alarm_code(alarm_code), .led_blinks(led_blinks),
    .motor_excite(motor_excite), .brake_engage(brake_engage), .ovld_thresh(ovld_thresh),
    .devi_thresh(devi_thresh));
  dad_far_model i_dad_far_model (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .link_up(link_up), .fail_p(fail_p), .alarm_p(alarm_p), .drop_p(drop_p));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Whole sequence needs about 380 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      $display("wrong value at %0t: timeout", $time);
      complete_run();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
      n_compared++;
      if (got !== exp) begin
        errors++;
        $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
    end
  endtask
  task st(input int n);
    begin
      repeat (n) @(posedge pclk);
      #1;
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      chk(pslverr, e, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task do_reset(input logic bad);
    begin
      presetn <= 1'b0;
      boot_bad <= bad;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      st(3);
    end
  endtask
  task pulse(input int b);
    begin
      @(posedge pclk);
      ev_bits[b] <= 1'b1;
      @(posedge pclk);
      ev_bits[b] <= 1'b0;
    end
  endtask
  task far(input logic [2:0] c);
    begin
      @(posedge pclk);
      cmd_valid <= 1'b1;
      cmd <= c;
      @(posedge pclk);
      cmd_valid <= 1'b0;
    end
  endtask
  task pin_clear;
    begin
      @(posedge pclk);
      clr_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      clr_pin <= 1'b0;
      st(2);
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, clr_pin, boot_bad, cmd_valid} = '0;
    {paddr, pwdata, ev_bits, cmd} = '0;
    {errors, n_compared, cycles} = '0;
    presetn = 1'b0;
    rows = '{'{12, 8'h70, 4'h7, 1'b1, 1'b1}, '{11, 8'h70, 4'h7, 1'b1, 1'b1}, '{10, 8'h70, 4'h7, 1'b1, 1'b1},
      '{9, 8'h71, 4'h7, 1'b0, 1'b0}, '{6, 8'h83, 4'h7, 1'b0, 1'b0}, '{0, 8'hf0, 4'hf, 1'b0, 1'b0}};
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      pulse(rows[i].b);
      st(1);
      chk(alarm_code, rows[i].code, "code");
      chk(led_blinks, rows[i].bl, "blinks");
      if (rows[i].code != 8'hf0) begin
        chk(motor_excite, rows[i].exc, "excite");
        chk(brake_engage, !rows[i].exc, "brake");
      end
      pin_clear();
      chk(alarm_active, !rows[i].rst, "after clear");
      if (!rows[i].rst)
        do_reset(1'b0);
      $display("row %0d done", i);
    end
    // Reset values and register refusals
    chk({alarm_active, alarm_code, motor_excite, brake_engage}, 11'h002, "reset outputs");
    chk(ovld_thresh, 16'd50, "overload default");
    chk(devi_thresh, 16'd300, "deviation default");
    apb(1'b0, 12'h004, 32'h0, 1'b0);
    chk(rdat & 32'hff03, 32'h2, "status idle");
    apb(1'b0, 12'h010, 32'h0, 1'b0);
    chk(rdat, 32'h3, "error threshold");
    apb(1'b1, 12'h008, 32'd0, 1'b1);
    apb(1'b1, 12'h008, 32'd301, 1'b1);
    apb(1'b1, 12'h008, 32'd300, 1'b0);
    apb(1'b1, 12'h00c, 32'd30001, 1'b1);
    apb(1'b1, 12'h00c, 32'd30000, 1'b0);
    st(1);
    chk({ovld_thresh, devi_thresh}, {16'd300, 16'd30000}, "thresholds");
    apb(1'b1, 12'h004, 32'h0, 1'b1);
    apb(1'b0, 12'h018, 32'h0, 1'b1);
    $display("registers done");
    // Converter alarm cleared over the bus
    far(3'h3);
    st(2);
    chk({alarm_code, motor_excite, brake_engage}, {8'h8e, 2'b01}, "converter alarm");
    apb(1'b1, 12'h000, 32'h1, 1'b0);
    st(1);
    chk(alarm_active, 1'b0, "bus clear");
    // Master disconnect then a locking alarm replaces it
    far(3'h4);
    st(2);
    chk({alarm_code, motor_excite}, {8'h81, 1'b1}, "disconnect");
    pulse(9);
    st(1);
    chk(alarm_code, 8'h71, "replace");
    do_reset(1'b0);
    // Third converter failure in a row
    far(3'h2);
    far(3'h2);
    st(3);
    chk(alarm_active, 1'b0, "two failures");
    far(3'h2);
    st(3);
    chk(alarm_code, 8'h84, "three failures");
    far(3'h1);
    pin_clear();
    // Serial error count restarts on a good frame
    for (int k = 0; k < 5; k++) begin
      pulse(k == 2 ? 4 : 5);
    end
    st(2);
    chk(alarm_active, 1'b0, "broken run");
    pulse(5);
    st(1);
    chk(alarm_code, 8'h84, "error count");
    pin_clear();
    // Converter link down too long
    far(3'h0);
    st(40);
    chk(alarm_active, 1'b0, "link early");
    st(20);
    chk(alarm_code, 8'h85, "link timeout");
    far(3'h1);
    pin_clear();
    // Master silent past the configured timeout
    apb(1'b1, 12'h014, 32'd3, 1'b0);
    pulse(4);
    st(20);
    chk(alarm_active, 1'b0, "master early");
    st(30);
    chk(alarm_code, 8'h85, "master timeout");
    apb(1'b1, 12'h014, 32'd0, 1'b0);
    pin_clear();
    $display("link tests done");
    // Mismatch at power-up locks until the next reset
    do_reset(1'b1);
    chk({alarm_code, motor_excite, brake_engage}, {8'h72, 2'b01}, "boot mismatch");
    pin_clear();
    chk(alarm_code, 8'h72, "boot locked");
    do_reset(1'b0);
    chk(alarm_active, 1'b0, "boot recovered");
    $display("boot test done");
    complete_run();
  end
endmodule
